// ### rtl/ipee_pkg.sv
// package for the interrupt priority and extended enable slice
// assumes a single core clock and a byte-wide special-function register port
package ipee_pkg;

    // ************************************************************
    // register addresses
    // ************************************************************
    localparam logic [7:0] IPEE_ADDR_PRIO_CORE  = 8'hb8;
    localparam logic [7:0] IPEE_ADDR_EXT_EN     = 8'he6;
    localparam logic [7:0] IPEE_ADDR_SVC_STATUS = 8'hd5;
    localparam logic [7:0] IPEE_ADDR_PEND_LO    = 8'hd6;
    localparam logic [7:0] IPEE_ADDR_PEND_HI    = 8'hd7;
    // bit addresses of the priority register run base .. base+7
    localparam logic [4:0] IPEE_BITADDR_PRIO_HI = 5'h17;

    // ************************************************************
    // reset values and masks
    // ************************************************************
    localparam logic [7:0] IPEE_RST_PRIO_CORE   = 8'h80;
    localparam logic [7:0] IPEE_RST_EXT_EN      = 8'h00;
    localparam logic [7:0] IPEE_PRIO_FIXED_ONE  = 8'h80;
    localparam logic [7:0] IPEE_EXT_EN_WR_MASK  = 8'hbd;
    localparam logic [7:0] IPEE_RDATA_IDLE      = 8'h00;

    // ************************************************************
    // field positions of the extended enable register
    // ************************************************************
    localparam int IPEE_EN_TIMER3_BIT = 7;
    localparam int IPEE_EN_CMP_BIT    = 5;
    localparam int IPEE_EN_PCA_BIT    = 4;
    localparam int IPEE_EN_CONV_BIT   = 3;
    localparam int IPEE_EN_WIN_BIT    = 2;
    localparam int IPEE_EN_SMB_BIT    = 0;

    // ************************************************************
    // sources, in fixed priority order (lower index wins)
    // ************************************************************
    localparam int IPEE_NUM_CORE   = 7;
    localparam int IPEE_NUM_SRC    = 15;
    localparam int IPEE_SRC_W      = 4;
    localparam int IPEE_SRC_SMB    = 7;
    localparam int IPEE_SRC_WIN    = 9;
    localparam int IPEE_SRC_CONV   = 10;
    localparam int IPEE_SRC_PCA    = 11;
    localparam int IPEE_SRC_CMP    = 12;
    localparam int IPEE_SRC_TIMER3 = 14;
    localparam int IPEE_PCA_FLAGS  = 4;

    // vector address = base + order * 8
    localparam logic [15:0] IPEE_VEC_BASE  = 16'h0003;
    localparam int          IPEE_VEC_SHIFT = 3;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        IPEE_SVC_NONE = 3'b001,
        IPEE_SVC_LOW  = 3'b010,
        IPEE_SVC_HIGH = 3'b100
    } ipee_svc_t;

    typedef struct packed {
        logic        timer3_low_overflow_flag;
        logic        timer3_high_overflow_flag;
        logic [1:0]  comparator_flags;
        logic [IPEE_PCA_FLAGS-1:0] counter_array_flags;
        logic        conversion_done_flag;
        logic        window_compare_flag;
        logic        smbus_flag;
    } ipee_flags_t;

    typedef struct packed {
        logic                  valid;
        logic                  high;
        logic [IPEE_SRC_W-1:0] index;
        logic [15:0]           vector;
    } ipee_req_t;

    typedef struct packed {
        logic [7:0] prio_core;
        logic [7:0] ext_en;
        ipee_svc_t  svc;
        logic       low_nested;
        ipee_req_t  req;
        logic [7:0] rdata;
    } ipee_state_t;

endpackage : ipee_pkg

// ### rtl/ipee_src_gate.sv
// source gating: raw pending flags to masked requests with their level
// assumes flags and masks all come from logic on the core clock
`timescale 1ns/1ps
`default_nettype none
module ipee_src_gate
    import ipee_pkg::*;
(
    // masks and levels
    input  wire logic                     global_irq_enable,
    input  wire logic [7:0]               prio_core,
    input  wire logic [7:0]               ext_en,
    input  wire logic [7:0]               ext_prio,
    // pending sources
    input  wire logic [IPEE_NUM_CORE-1:0] core_req,
    input  wire ipee_flags_t              flags,
    // gated requests
    output logic      [IPEE_NUM_SRC-1:0]  src_req,
    output logic      [IPEE_NUM_SRC-1:0]  src_high
);
    logic [IPEE_NUM_SRC-1:0] raw;
    logic [IPEE_NUM_SRC-1:0] en;
    logic [IPEE_NUM_SRC-1:0] lvl;

    always_comb begin
        raw = '0;
        en  = '0;
        lvl = '0;
        // core sources arrive already masked by the base enable register
        raw[IPEE_NUM_CORE-1:0] = core_req;
        en[IPEE_NUM_CORE-1:0]  = '1;
        lvl[IPEE_NUM_CORE-1:0] = prio_core[IPEE_NUM_CORE-1:0];
        raw[IPEE_SRC_TIMER3] = flags.timer3_low_overflow_flag | flags.timer3_high_overflow_flag;
        en[IPEE_SRC_TIMER3]  = ext_en[IPEE_EN_TIMER3_BIT];
        lvl[IPEE_SRC_TIMER3] = ext_prio[IPEE_EN_TIMER3_BIT];
        raw[IPEE_SRC_CMP]    = |flags.comparator_flags;
        en[IPEE_SRC_CMP]     = ext_en[IPEE_EN_CMP_BIT];
        lvl[IPEE_SRC_CMP]    = ext_prio[IPEE_EN_CMP_BIT];
        raw[IPEE_SRC_PCA]    = |flags.counter_array_flags;
        en[IPEE_SRC_PCA]     = ext_en[IPEE_EN_PCA_BIT];
        lvl[IPEE_SRC_PCA]    = ext_prio[IPEE_EN_PCA_BIT];
        raw[IPEE_SRC_CONV]   = flags.conversion_done_flag;
        en[IPEE_SRC_CONV]    = ext_en[IPEE_EN_CONV_BIT];
        lvl[IPEE_SRC_CONV]   = ext_prio[IPEE_EN_CONV_BIT];
        raw[IPEE_SRC_WIN]    = flags.window_compare_flag;
        en[IPEE_SRC_WIN]     = ext_en[IPEE_EN_WIN_BIT];
        lvl[IPEE_SRC_WIN]    = ext_prio[IPEE_EN_WIN_BIT];
        raw[IPEE_SRC_SMB]    = flags.smbus_flag;
        en[IPEE_SRC_SMB]     = ext_en[IPEE_EN_SMB_BIT];
        lvl[IPEE_SRC_SMB]    = ext_prio[IPEE_EN_SMB_BIT];
    end

    genvar g;
    generate
        for (g = 0; g < IPEE_NUM_SRC; g = g + 1) begin : g_gate
            // global enable overrides every source mask
            assign src_req[g]  = global_irq_enable & raw[g] & en[g];
            assign src_high[g] = lvl[g];
        end
    endgenerate
endmodule : ipee_src_gate
`default_nettype wire

// ### rtl/ipee_prio_pick.sv
// priority pick: high level first, then lowest order among requests that the current level admits
// assumes one-cycle combinational use inside the controller
`timescale 1ns/1ps
`default_nettype none
module ipee_prio_pick #(
    parameter int N = 15,
    parameter int W = 4
) (
    // candidates
    input  wire logic [N-1:0] req,
    input  wire logic [N-1:0] high,
    // admission by the service in progress
    input  wire logic         allow_high,
    input  wire logic         allow_low,
    // choice
    output logic              found,
    output logic              found_high,
    output logic [W-1:0]      index
);
    logic [N-1:0] hi_ok;
    logic [N-1:0] lo_ok;

    always_comb begin
        hi_ok      = req & high & {N{allow_high}};
        lo_ok      = req & ~high & {N{allow_low}};
        found      = 1'b0;
        found_high = 1'b0;
        index      = '0;
        // high level first, then the lowest order within a level
        if (|hi_ok) begin
            found      = 1'b1;
            found_high = 1'b1;
            for (int i = N - 1; i >= 0; i--) begin
                if (hi_ok[i]) begin
                    index = W'(i);
                end
            end
        end else if (|lo_ok) begin
            found = 1'b1;
            for (int i = N - 1; i >= 0; i--) begin
                if (lo_ok[i]) begin
                    index = W'(i);
                end
            end
        end
    end
endmodule : ipee_prio_pick
`default_nettype wire

// ### rtl/ipee_ctrl.sv
// interrupt priority and extended enable slice with request sequencing
// assumes a byte register port on the core clock and a core that
// acknowledges a presented request and signals the end of each service
//
// Function
// - priority register 0xB8, bit-addressable, bit7 reads one
// - extended enable 0xE6, reset zero, bits 6,1 reserved
// - bit7 gates timer3 low or high overflow
// - bits 5,4,3,2,0 gate their own sources
// - global enable overrides every source mask
// - window compare 0x004B order 9, conversion 0x0053 order 10
`timescale 1ns/1ps
`default_nettype none
module ipee_ctrl
    import ipee_pkg::*;
(
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // byte register port
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [7:0]               reg_rdata,
    // single-bit write port
    input  wire logic [7:0]               bit_addr,
    input  wire logic                     bit_wdata,
    input  wire logic                     bit_wr,
    // neighbouring registers outside this slice
    input  wire logic                     global_irq_enable,
    input  wire logic [7:0]               ext_prio,
    // pending sources
    input  wire logic [IPEE_NUM_CORE-1:0] core_req,
    input  wire ipee_pkg::ipee_flags_t    flags,
    // core sequencer
    output ipee_pkg::ipee_req_t           req,
    input  wire logic                     req_ack,
    input  wire logic                     svc_return,
    // register views
    output logic      [7:0]               prio_core,
    output logic      [7:0]               ext_en
);
    import ipee_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    ipee_state_t st_r;
    ipee_state_t st_nxt;

    logic [IPEE_NUM_SRC-1:0] src_req;
    logic [IPEE_NUM_SRC-1:0] src_high;
    logic                    allow_high;
    logic                    allow_low;
    logic                    pick_found;
    logic                    pick_high;
    logic [IPEE_SRC_W-1:0]   pick_index;
    logic                    ack_taken;
    logic                    bit_hit;
    logic [2:0]              bit_sel;
    logic [7:0]              rd_mux;
    logic [7:0]              svc_status;
    logic [15:0]             pend_view;

    // ************************************************************
    // request gating and choice
    // ************************************************************
    ipee_src_gate u_gate (
        .global_irq_enable (global_irq_enable),
        .prio_core         (st_r.prio_core),
        .ext_en            (st_r.ext_en),
        .ext_prio          (ext_prio),
        .core_req          (core_req),
        .flags             (flags),
        .src_req           (src_req),
        .src_high          (src_high)
    );

    // a running high service blocks everything; a low one blocks only low
    assign allow_high = (st_r.svc != IPEE_SVC_HIGH);
    assign allow_low  = (st_r.svc == IPEE_SVC_NONE);

    ipee_prio_pick #(
        .N (IPEE_NUM_SRC),
        .W (IPEE_SRC_W)
    ) u_pick (
        .req        (src_req),
        .high       (src_high),
        .allow_high (allow_high),
        .allow_low  (allow_low),
        .found      (pick_found),
        .found_high (pick_high),
        .index      (pick_index)
    );

    // ************************************************************
    // decode helpers
    // ************************************************************
    assign ack_taken = req_ack & st_r.req.valid;
    assign bit_hit   = bit_wr & (bit_addr[7:3] == IPEE_BITADDR_PRIO_HI);
    assign bit_sel   = bit_addr[2:0];

    always_comb begin
        svc_status = 8'h00;
        svc_status[2:0] = st_r.svc;
        svc_status[3]   = st_r.low_nested;
        svc_status[4]   = st_r.req.valid;
        svc_status[5]   = st_r.req.high;
    end

    assign pend_view = {1'b0, src_req};

    // reserved bits read zero; bit 7 of the priority register reads one
    always_comb begin
        case (reg_addr)
            IPEE_ADDR_PRIO_CORE: begin
                rd_mux = st_r.prio_core | IPEE_PRIO_FIXED_ONE;
            end
            IPEE_ADDR_EXT_EN: begin
                rd_mux = st_r.ext_en & IPEE_EXT_EN_WR_MASK;
            end
            IPEE_ADDR_SVC_STATUS: begin
                rd_mux = svc_status;
            end
            IPEE_ADDR_PEND_LO: begin
                rd_mux = pend_view[7:0];
            end
            IPEE_ADDR_PEND_HI: begin
                rd_mux = pend_view[15:8];
            end
            default: begin
                rd_mux = IPEE_RDATA_IDLE;
            end
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;

        // read data stands for one cycle after the strobe only
        st_nxt.rdata = reg_rd ? rd_mux : IPEE_RDATA_IDLE;

        // byte writes
        if (reg_wr && reg_addr == IPEE_ADDR_PRIO_CORE) begin
            st_nxt.prio_core = (reg_wdata & ~IPEE_PRIO_FIXED_ONE) | IPEE_PRIO_FIXED_ONE;
        end
        if (reg_wr && reg_addr == IPEE_ADDR_EXT_EN) begin
            st_nxt.ext_en = reg_wdata & IPEE_EXT_EN_WR_MASK;
        end

        // bit writes; the unused top bit ignores them
        if (bit_hit && bit_sel != 3'd7) begin
            st_nxt.prio_core[bit_sel] = bit_wdata;
        end

        // service tracking: ack wins over a return in the same cycle,
        // and that return is dropped; the preempted low service resumes after the high return
        case (st_r.svc)
            IPEE_SVC_NONE: begin
                if (ack_taken) begin
                    st_nxt.svc        = st_r.req.high ? IPEE_SVC_HIGH : IPEE_SVC_LOW;
                    st_nxt.low_nested = 1'b0;
                end
            end
            IPEE_SVC_LOW: begin
                if (ack_taken && st_r.req.high) begin
                    st_nxt.svc        = IPEE_SVC_HIGH;
                    st_nxt.low_nested = 1'b1;
                end else if (svc_return) begin
                    st_nxt.svc = IPEE_SVC_NONE;
                end
            end
            IPEE_SVC_HIGH: begin
                if (svc_return) begin
                    st_nxt.svc        = st_r.low_nested ? IPEE_SVC_LOW : IPEE_SVC_NONE;
                    st_nxt.low_nested = 1'b0;
                end
            end
            default: begin
                st_nxt.svc        = IPEE_SVC_NONE;
                st_nxt.low_nested = 1'b0;
            end
        endcase

        // presented request; withdrawn for one cycle after an ack so the
        // same source cannot be taken twice before its flag clears
        st_nxt.req.valid  = pick_found & ~ack_taken;
        st_nxt.req.high   = pick_found & pick_high & ~ack_taken;
        st_nxt.req.index  = pick_index;
        st_nxt.req.vector = IPEE_VEC_BASE + (16'(pick_index) << IPEE_VEC_SHIFT);
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r.prio_core  <= IPEE_RST_PRIO_CORE;
            st_r.ext_en     <= IPEE_RST_EXT_EN;
            st_r.svc        <= IPEE_SVC_NONE;
            st_r.low_nested <= 1'b0;
            st_r.req        <= '0;
            st_r.rdata      <= IPEE_RDATA_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rdata = st_r.rdata;
    assign req       = st_r.req;
    assign prio_core = st_r.prio_core;
    assign ext_en    = st_r.ext_en;

endmodule : ipee_ctrl
`default_nettype wire

// ### tb/ipee_chk.sv
// checker for the interrupt priority and extended enable slice
// assumes it is bound onto ipee_ctrl and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ipee_chk (
    // clock and reset
    input wire logic                core_clk,
    input wire logic                rst,
    // register port and views
    input wire logic [7:0]          reg_addr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_rdata,
    input wire logic [7:0]          prio_core,
    input wire logic [7:0]          ext_en,
    // sources and sequencer
    input wire logic                global_irq_enable,
    input wire ipee_pkg::ipee_flags_t flags,
    input wire ipee_pkg::ipee_req_t req,
    input wire logic                req_ack
);
    import ipee_pkg::*;
    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_prio_top; prio_core[7]; endproperty
    property p_ext_rsvd; !ext_en[6] && !ext_en[1]; endproperty
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    property p_rd_prio; $past(reg_rd) && $past(reg_addr) == 8'hb8 |-> reg_rdata == $past(prio_core); endproperty
    property p_rd_ext; $past(reg_rd) && $past(reg_addr) == 8'he6 |-> reg_rdata == $past(ext_en); endproperty
    property p_global_off; !$past(global_irq_enable) |-> !req.valid; endproperty
    property p_vector; req.valid |-> req.vector == 16'h0003 + {9'h000, req.index, 3'b000}; endproperty
    property p_t3_gate;
        req.valid && req.index == 4'he |->
            $past(ext_en[7] && (flags.timer3_low_overflow_flag || flags.timer3_high_overflow_flag));
    endproperty
    property p_win_gate; req.valid && req.index == 4'h9 |-> $past(ext_en[2] && flags.window_compare_flag); endproperty
    property p_ack_low; req_ack && req.valid && !req.high |=> !req.valid ##1 (!req.valid || req.high); endproperty
    property p_ack_high; req_ack && req.valid && req.high |=> !req.valid [*2]; endproperty
    a_prio_top: assert property (p_prio_top) else $error("priority top bit not one");
    a_ext_rsvd: assert property (p_ext_rsvd) else $error("reserved enable bit set");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_rd_prio: assert property (p_rd_prio) else $error("priority read mismatch");
    a_rd_ext: assert property (p_rd_ext) else $error("enable read mismatch");
    a_global_off: assert property (p_global_off) else $error("request with global enable off");
    a_vector: assert property (p_vector) else $error("vector does not match order");
    a_t3_gate: assert property (p_t3_gate) else $error("timer3 request not gated");
    a_win_gate: assert property (p_win_gate) else $error("window request not gated");
    a_ack_low: assert property (p_ack_low) else $error("low request during low service");
    a_ack_high: assert property (p_ack_high) else $error("request during high service");
    c_win: cover property (req.valid && req.index == 4'h9 && req_ack);
    c_high: cover property (req.valid && req.high && req_ack);
    c_rd_ext: cover property ($past(reg_rd) && $past(reg_addr) == 8'he6);
endmodule : ipee_chk
bind ipee_ctrl ipee_chk ipee_chk_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .prio_core(prio_core), .ext_en(ext_en), .global_irq_enable(global_irq_enable),
    .flags(flags), .req(req), .req_ack(req_ack));
`default_nettype wire

// ### tb/ipee_core_model.sv
// core sequencer model: acks presented requests, nests, returns from service
// assumes req is registered by the slice on the same clock
`timescale 1ns/1ps
`default_nettype none
module ipee_core_model (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst,
    // sequencer side
    input  wire ipee_pkg::ipee_req_t req,
    input  wire logic               slow,
    output logic                    req_ack,
    output logic                    svc_return,
    output logic                    busy
);
    import ipee_pkg::*;
    localparam int SVC_LEN = 8;
    int wait_cnt;
    int svc_cnt;
    int depth;
    assign busy = (depth != 0);
    // never ack and return together, never ack twice on one request
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req_ack    <= 1'b0;
            svc_return <= 1'b0;
            wait_cnt   <= 0;
            svc_cnt    <= 0;
            depth      <= 0;
        end else begin
            req_ack    <= 1'b0;
            svc_return <= 1'b0;
            if (req.valid && !req_ack && svc_cnt != 1 && wait_cnt >= (slow ? 3 : 0)) begin
                req_ack  <= 1'b1;
                wait_cnt <= 0;
                svc_cnt  <= SVC_LEN;
                depth    <= depth + 1;
            end else if (svc_cnt == 1) begin
                svc_return <= 1'b1;
                depth      <= depth - 1;
                svc_cnt    <= (depth > 1) ? SVC_LEN : 0;
            end else begin
                wait_cnt <= req.valid ? wait_cnt + 1 : 0;
                if (svc_cnt > 1) svc_cnt <= svc_cnt - 1;
            end
        end
    end
endmodule : ipee_core_model
`default_nettype wire

// ### tb/interrupt_priority_and_ext_enable_bench.sv
// self-checking bench for the interrupt priority and extended enable slice
// assumes ipee_ctrl, the core model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_and_ext_enable_bench;
    import ipee_pkg::*;
    logic        core_clk, rst, reg_wr, reg_rd, bit_wdata, bit_wr, global_irq_enable, slow;
    logic [7:0]  reg_addr, reg_wdata, bit_addr, reg_rdata, prio_core, ext_en, lf;
    logic [6:0]  core_req;
    ipee_flags_t flags;
    ipee_req_t   req;
    logic        req_ack, svc_return, busy;
    int          err_count, tests_run;
    localparam int EN_POS[7] = '{7, 7, 5, 4, 3, 2, 0};
    localparam int IDX[7]    = '{14, 14, 12, 11, 10, 9, 7};

    ipee_ctrl ipee_ctrl_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_addr(bit_addr), .bit_wdata(bit_wdata),
        .bit_wr(bit_wr), .global_irq_enable(global_irq_enable), .ext_prio(8'h00), .core_req(core_req),
        .flags(flags), .req(req), .req_ack(req_ack), .svc_return(svc_return), .prio_core(prio_core),
        .ext_en(ext_en));
    ipee_core_model ipee_core_model_i (.core_clk(core_clk), .rst(rst), .req(req), .slow(slow),
        .req_ack(req_ack), .svc_return(svc_return), .busy(busy));

    // ************************************************************
    // expectations and bus tasks
    // ************************************************************
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    function automatic ipee_flags_t mk_flag(input int k);
        ipee_flags_t f;
        f = '0;
        case (k)
            0: f.timer3_low_overflow_flag = 1'b1;
            1: f.timer3_high_overflow_flag = 1'b1;
            2: f.comparator_flags[0] = 1'b1;
            3: f.counter_array_flags[2] = 1'b1;
            4: f.conversion_done_flag = 1'b1;
            5: f.window_compare_flag = 1'b1;
            default: f.smbus_flag = 1'b1;
        endcase
        return f;
    endfunction : mk_flag
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", 16'(reg_rdata), 16'(exp));
    endtask : rd
    task automatic bitw(input logic [7:0] a, input logic v);
        @(posedge core_clk);
        bit_wr    <= 1'b1;
        bit_addr  <= a;
        bit_wdata <= v;
        @(posedge core_clk);
        bit_wr <= 1'b0;
        #1;
    endtask : bitw
    task automatic give_up();
        err_count++;
        print_verdict();
    endtask : give_up
    task automatic expect_req(input int idx, input logic hi);
        int i;
        for (i = 0; i < 8 && req.valid !== 1'b1; i++) @(posedge core_clk) #1;
        if (i == 8) give_up();
        check("req.index", 16'(req.index), 16'(idx));
        check("req.high", 16'(req.high), 16'(hi));
        check("req.vector", req.vector, 16'h0003 + 16'(idx * 8));
    endtask : expect_req
    task automatic expect_none(input int n);
        repeat (n) @(posedge core_clk) #1 check("req.valid", 16'(req.valid), 16'h0000);
    endtask : expect_none
    // sources are cleared only once the core has taken the request
    task automatic take(input logic [6:0] nc);
        int i;
        for (i = 0; i < 8 && req_ack !== 1'b1; i++) @(posedge core_clk) #1;
        if (i == 8) give_up();
        @(posedge core_clk);
        flags    <= '0;
        core_req <= nc;
        // let the edge that takes the ack settle before req is looked at
        #1;
    endtask : take
    task automatic idle();
        int i;
        for (i = 0; i < 60 && busy !== 1'b0; i++) @(posedge core_clk) #1;
        if (i == 60) give_up();
    endtask : idle
    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        #1;
    endtask : do_reset

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {rst, reg_wr, reg_rd, bit_wr, bit_wdata, slow} = 6'b100000;
        {reg_addr, reg_wdata, bit_addr, core_req, flags} = '0;
        global_irq_enable = 1'b1;
        err_count = 0;
        tests_run = 0;
        lf = 8'h3f;
        do_reset();
        rd(8'hb8, 8'h80);
        rd(8'he6, 8'h00);
        // status reads idle service one-hot, nothing pending in the high pending byte
        rd(8'hd5, 8'h01);
        rd(8'hd7, 8'h00);
        wr(8'h11, 8'hff);
        rd(8'h11, 8'h00);
        for (int i = 0; i < 8; i++) begin
            lf = lfsr(lf);
            wr(8'hb8, lf);
            check("prio_core", 16'(prio_core), 16'(lf | 8'h80));
            rd(8'hb8, lf | 8'h80);
            wr(8'he6, ~lf);
            rd(8'he6, ~lf & 8'hbd);
        end
        wr(8'hb8, 8'h00);
        for (int n = 0; n < 8; n++) bitw(8'(8'hb8 + n), 1'b1);
        bitw(8'hbc, 1'b0);
        check("prio_core", 16'(prio_core), 16'h00ef);
        wr(8'hb8, 8'h00);
        for (int k = 0; k < 7; k++) begin
            slow <= k[0];
            wr(8'he6, ~(8'h01 << EN_POS[k]));
            flags <= mk_flag(k);
            expect_none(4);
            wr(8'he6, 8'h01 << EN_POS[k]);
            expect_req(IDX[k], 1'b0);
            take(7'h00);
            idle();
        end
        core_req <= 7'h0a;
        expect_req(1, 1'b0);
        take(7'h00);
        idle();
        wr(8'hb8, 8'h09);
        core_req <= 7'h0a;
        expect_req(3, 1'b1);
        take(7'h00);
        idle();
        global_irq_enable <= 1'b0;
        wr(8'he6, 8'h04);
        flags <= mk_flag(5);
        expect_none(4);
        global_irq_enable <= 1'b1;
        expect_req(9, 1'b0);
        take(7'h01);
        expect_req(0, 1'b1);
        take(7'h00);
        idle();
        do_reset();
        check("prio_core", 16'(prio_core), 16'h0080);
        check("ext_en", 16'(ext_en), 16'h0000);
        print_verdict();
    end
endmodule : interrupt_priority_and_ext_enable_bench
`default_nettype wire
